//--- rtl/pot_pkg.sv
/*
 * Package of the prescaled 16-bit overflow timer: register map,
 * field positions, reset values, response codes, carrier types.
 * Assumes an AXI4-Lite master with 32-bit data on the same clock.
 */
package pot_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'h05;
   localparam logic [7:0] IDX_COUNT_LO = 8'h0b;
   localparam logic [7:0] IDX_COUNT_HI = 8'h0c;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
   localparam int ADDR_W = 12;

   // control register fields
   localparam int CTL_RISING_BIT = 6;
   localparam int CTL_INTERNAL_BIT = 5;
   localparam int CTL_PS_MSB = 4;
   localparam int CTL_PS_LSB = 1;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CTL_WMASK = 8'h7e;

   // status and mask register: bit 0 is the overflow event
   localparam int IRQ_OVF_BIT = 0;
   localparam logic IRQ_MASK_RESET = 1'b0;

   // timing
   localparam int OSC_MHZ = 100;
   localparam int OSC_PER_INSTR = 4;
   localparam logic [1:0] PH_SAMPLE_A = 2'h1;
   localparam logic [1:0] PH_LAST = 2'h3;
   localparam logic [3:0] PS_MAX_CODE = 4'h8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic rising_edge_select;
      logic internal_source_select;
      logic [3:0] prescale_ratio_field;
   } pot_ctrl_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } pot_req_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } pot_rd_state_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } pot_wr_state_t;
endpackage

//--- rtl/pot_timer.sv
/*
 * Prescaled 16-bit overflow timer with an 8-bit prescaler,
 * internal instruction-clock or external pin source, overflow
 * interrupt, and an AXI4-Lite register slave.
 * Assumes clock_in is the oscillator; the external pin and the
 * vector acknowledge are synchronous to clock_in.
 */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: count is 16 bits, reached as separate low and high byte registers.
// RULE2: prescale choice sits in control bits 4:1, ratios 1:1 to 1:256.
// RULE3: control bit 5 set counts instruction clock; clear counts pin edges.
// RULE4: in pin mode bit 6 set picks rising edges, clear picks falling.
// RULE5: count runs 0000h to FFFFh, wraps to zero and sets overflow flag.
// RULE6: interrupt is raised from the flag only while its enable is set.
// RULE7: flag clears by itself when the processor vectors to the interrupt.
// RULE8: internal source is the oscillator divided by four.
// RULE9: pin path is synchronised after the prescaler, sampled twice per cycle.
// RULE10: pin edge reaches the count three to seven oscillator periods later (prescale codes above 0 add the ps_q register stage, up to eight).
// RULE11: prescaler counts raw pin edges ahead of synchronisation.
// RULE12: edge selection applies only to the external source.
// RULE13: byte write blocks that byte's increment next cycle, not the other; here a low write also blocks the high byte's carry increment.
// RULE14: any count byte write clears the prescaler.
// RULE15: prescale code 0 is 1:1, each code doubles, codes 8 up are 1:256.
// RULE16: prescaler count is hidden; only its synchronised output advances count (internal mode decodes ps_q bits at instr_en instead).
module pot_timer (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic external_count_input_in,
   input wire logic vector_ack_in,
   input wire logic [pot_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [pot_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic irq_out
);
   import pot_pkg::*;

   function automatic logic [7:0] ps_mask(input logic [3:0] code);
      logic [7:0] m;
      m = 8'hff;
      if (code < PS_MAX_CODE) begin
         m = 8'((9'h001 << code) - 9'h001);
      end
      return m;
   endfunction

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      return a[9:2];
   endfunction

   pot_ctrl_t ctrl_q;
   logic [15:0] count_q;
   logic [7:0] ps_q;
   logic [1:0] phase_q;
   logic pin_q, pin_prev_q;
   logic psamp_q, pend_q;
   logic inh_lo_q, inh_hi_q;
   logic flag_q, flag_d, irq_en_q, irq_q;
   pot_rd_state_t rd_state_q;
   pot_wr_state_t wr_state_q;
   pot_req_t aw_q;
   logic w_got_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   logic instr_en, sample_en, pin_edge, ps_tick, prescaler_output;
   logic inc_int, inc_ext, inc, lo_inc, hi_inc, ovf;
   logic wr_fire, wr_lo, wr_hi, wr_any, wr_ctl, wr_stat, wr_mask;
   logic [7:0] wr_idx, rd_idx;

   // RULE8: oscillator divided by four
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end
   assign instr_en = (phase_q == PH_LAST);
   // RULE9: two samples per instruction cycle
   assign sample_en = (phase_q == PH_SAMPLE_A) || (phase_q == PH_LAST);

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_q <= external_count_input_in;
         pin_prev_q <= pin_q;
      end
   end

   // RULE4: chosen pin edge
   assign pin_edge = ctrl_q.rising_edge_select ? (pin_q & ~pin_prev_q) : (~pin_q & pin_prev_q);
   // RULE3: source choice; RULE12: edge choice only on the pin path
   assign ps_tick = ctrl_q.internal_source_select ? instr_en : pin_edge;

   // RULE11: raw edges counted ahead of synchronisation
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ps_q <= 8'h00;
      end else if (wr_any) begin
         // RULE14: count byte write clears prescaler
         ps_q <= 8'h00;
      end else if (ps_tick) begin
         ps_q <= ps_q + 8'h01;
      end
   end

   // RULE15: code 0 passes the pin, higher codes tap a prescaler bit
   always_comb begin
      prescaler_output = pin_q ^ ~ctrl_q.rising_edge_select;
      if (ctrl_q.prescale_ratio_field >= PS_MAX_CODE) begin
         prescaler_output = ps_q[7];
      end else if (ctrl_q.prescale_ratio_field != 4'h0) begin
         prescaler_output = ps_q[3'(ctrl_q.prescale_ratio_field - 4'h1)];
      end
   end

   // RULE9: sample prescaler output, hold a pending increment
   // RULE10: pin register, sample and cycle end give 3 to 7 periods
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         // idle output level of the reset falling mode, no false edge
         psamp_q <= 1'b1;
         pend_q <= 1'b0;
      end else begin
         if (sample_en) begin
            psamp_q <= prescaler_output;
         end
         if (sample_en && prescaler_output && !psamp_q) begin
            pend_q <= 1'b1;
         end else if (instr_en || ctrl_q.internal_source_select) begin
            pend_q <= 1'b0;
         end
      end
   end

   // RULE16: pin mode counts the synchronised prescaler output; internal mode decodes ps_q bits at instr_en
   assign inc_ext = !ctrl_q.internal_source_select && instr_en && pend_q;
   assign inc_int = ctrl_q.internal_source_select && instr_en &&
                    ((ps_q & ps_mask(ctrl_q.prescale_ratio_field)) == ps_mask(ctrl_q.prescale_ratio_field));
   assign inc = inc_int || inc_ext;
   // RULE13: per-byte increment blocking after a write
   assign lo_inc = inc && !inh_lo_q;
   assign hi_inc = lo_inc && (count_q[7:0] == 8'hff) && !inh_hi_q;
   // RULE5: wrap from all ones
   assign ovf = hi_inc && (count_q == 16'hffff);

   // RULE1: two byte halves of one count
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_q <= 16'h0000;
      end else begin
         if (wr_lo) begin
            count_q[7:0] <= wdata_q[7:0];
         end else if (lo_inc) begin
            count_q[7:0] <= count_q[7:0] + 8'h01;
         end
         if (wr_hi) begin
            count_q[15:8] <= wdata_q[7:0];
         end else if (hi_inc) begin
            count_q[15:8] <= count_q[15:8] + 8'h01;
         end
      end
   end

   // RULE13: block flags last one cycle
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         inh_lo_q <= 1'b0;
         inh_hi_q <= 1'b0;
      end else begin
         inh_lo_q <= wr_lo;
         inh_hi_q <= wr_hi;
      end
   end

   // RULE7: vector acknowledge clears; overflow in the same cycle wins
   always_comb begin
      flag_d = flag_q;
      if (vector_ack_in || (wr_stat && wdata_q[IRQ_OVF_BIT])) begin
         flag_d = 1'b0;
      end
      if (ovf) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_en_q <= IRQ_MASK_RESET;
      end else if (wr_mask) begin
         irq_en_q <= wdata_q[IRQ_OVF_BIT];
      end
   end

   // RULE6: request only while enabled
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_d && (wr_mask ? wdata_q[IRQ_OVF_BIT] : irq_en_q);
      end
   end

   // RULE2: prescale field at control bits 4:1
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_q <= pot_ctrl_t'(CTL_RESET[CTL_RISING_BIT:CTL_PS_LSB]);
      end else if (wr_ctl) begin
         ctrl_q <= pot_ctrl_t'(wdata_q[CTL_RISING_BIT:CTL_PS_LSB]);
      end
   end

   // write path: address and data taken in either order
   assign wr_fire = (wr_state_q == WR_COLLECT) && aw_q.valid && w_got_q;
   assign wr_idx = reg_index(aw_q.addr);
   always_comb begin
      wr_lo = 1'b0;
      wr_hi = 1'b0;
      wr_ctl = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (!wr_fire || !wstrb_q[0]) begin
         wr_any = 1'b0;
      end else if (wr_idx == IDX_COUNT_LO) begin
         wr_lo = 1'b1;
         wr_any = 1'b1;
      end else if (wr_idx == IDX_COUNT_HI) begin
         wr_hi = 1'b1;
         wr_any = 1'b1;
      end else if (wr_idx == IDX_CONTROL) begin
         wr_ctl = 1'b1;
         wr_any = 1'b0;
      end else if (wr_idx == IDX_IRQ_STATUS) begin
         wr_stat = 1'b1;
         wr_any = 1'b0;
      end else if (wr_idx == IDX_IRQ_MASK) begin
         wr_mask = 1'b1;
         wr_any = 1'b0;
      end else begin
         wr_any = 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_state_q <= WR_COLLECT;
         aw_q <= '0;
         w_got_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
      end else begin
         case (wr_state_q)
            WR_COLLECT: begin
               if (s_axi_awvalid_in && !aw_q.valid) begin
                  aw_q <= '{valid: 1'b1, addr: s_axi_awaddr_in};
                  awready_q <= 1'b0;
               end
               if (s_axi_wvalid_in && !w_got_q) begin
                  w_got_q <= 1'b1;
                  wdata_q <= s_axi_wdata_in;
                  wstrb_q <= s_axi_wstrb_in;
                  wready_q <= 1'b0;
               end
               if (wr_fire) begin
                  wr_state_q <= WR_RESP;
                  bvalid_q <= 1'b1;
                  bresp_q <= (wr_idx == IDX_COUNT_LO || wr_idx == IDX_COUNT_HI ||
                              wr_idx == IDX_CONTROL || wr_idx == IDX_IRQ_STATUS ||
                              wr_idx == IDX_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (s_axi_bready_in) begin
                  wr_state_q <= WR_COLLECT;
                  bvalid_q <= 1'b0;
                  aw_q <= '0;
                  w_got_q <= 1'b0;
                  awready_q <= 1'b1;
                  wready_q <= 1'b1;
               end
            end
            default: begin
               wr_state_q <= WR_COLLECT;
            end
         endcase
      end
   end

   // read path
   assign rd_idx = reg_index(s_axi_araddr_in);
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_state_q <= RD_IDLE;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
         arready_q <= 1'b1;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               if (s_axi_arvalid_in) begin
                  rd_state_q <= RD_RESP;
                  arready_q <= 1'b0;
                  rvalid_q <= 1'b1;
                  rresp_q <= RESP_OKAY;
                  if (rd_idx == IDX_COUNT_LO) begin
                     rdata_q <= {24'h000000, count_q[7:0]};
                  end else if (rd_idx == IDX_COUNT_HI) begin
                     rdata_q <= {24'h000000, count_q[15:8]};
                  end else if (rd_idx == IDX_CONTROL) begin
                     rdata_q <= {25'h0000000, ctrl_q, 1'b0};
                  end else if (rd_idx == IDX_IRQ_STATUS) begin
                     rdata_q <= {31'h00000000, flag_q};
                  end else if (rd_idx == IDX_IRQ_MASK) begin
                     rdata_q <= {31'h00000000, irq_en_q};
                  end else begin
                     rdata_q <= 32'h0000_0000;
                     rresp_q <= RESP_SLVERR;
                  end
               end
            end
            RD_RESP: begin
               if (s_axi_rready_in) begin
                  rd_state_q <= RD_IDLE;
                  arready_q <= 1'b1;
                  rvalid_q <= 1'b0;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
            end
         endcase
      end
   end

   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out = wready_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;
   assign irq_out = irq_q;

   AST_IRQ_GATE: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE6
      irq_q == (flag_q && irq_en_q)) else $error("irq output disagrees with flag and enable");
   AST_OVF_FLAG: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE5
      ovf |=> flag_q && irq_q == irq_en_q) else $error("overflow did not set flag");
   AST_WRAP_ZERO: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE5
      (count_q == 16'hffff && ovf && !wr_lo && !wr_hi) |=> count_q == 16'h0000)
      else $error("count did not wrap to zero");
   AST_LO_BLOCK: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE13
      (wr_lo ##1 !wr_lo) |=> $stable(count_q[7:0])) else $error("low byte moved after its write");
   AST_PS_CLEAR: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE14
      (wr_lo || wr_hi) |=> ps_q == 8'h00) else $error("prescaler not cleared by count write");
   AST_VEC_CLEAR: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE7
      (vector_ack_in && !ovf) |=> !flag_q) else $error("vector acknowledge left flag set");
   AST_INT_PACE: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE8
      (ctrl_q.internal_source_select && !instr_en && !wr_lo && !wr_hi) |=> $stable(count_q))
      else $error("internal count moved off the instruction clock");
   AST_EXT_DELAY: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE10
      (pend_q && !ctrl_q.internal_source_select) |-> ##[0:3] (inc_ext || ctrl_q.internal_source_select))
      else $error("pending pin edge not counted in time");
   AST_INT_NO_EDGE: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE12
      (ctrl_q.internal_source_select && !instr_en && !wr_lo && !wr_hi) |=> $stable(ps_q))
      else $error("prescaler moved on pin edge in internal mode");
endmodule

//--- sim/pot_ext_clock.sv
/*
 * Far-side model: external count source driving the timer's count pin.
 * Assumes the pin is sampled on clock_in, so edges land just after a rising edge.
 */
`timescale 1ns/1ps
module pot_ext_clock (
   input wire logic clock_in,
   output logic pin_out
);
   initial begin
      pin_out = 1'h0;
   end

   task automatic toggle(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge clock_in);
         pin_out <= ~pin_out;
      end
   endtask
endmodule

//--- sim/test_pot_timer.sv
/*
 * Self-checking bench of the prescaled overflow timer: AXI4-Lite master tasks,
 * internal and pin-driven counting, prescaler clearing, overflow interrupt.
 * Assumes the external source model and a single 100 MHz clock.
 */
`timescale 1ns/1ps
module test_pot_timer;
   import pot_pkg::*;
   logic clock_in = 1'h0;
   logic arst_n = 1'h0;
   logic vec_ack = 1'h0;
   logic ext_pin;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int mismatches = 0;
   int tests_run = 0;
   int t_evt;

   always #5 clock_in = ~clock_in;

   pot_timer pot_timer_inst (.clock_in(clock_in), .arst_n_in(arst_n), .external_count_input_in(ext_pin),
      .vector_ack_in(vec_ack), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .irq_out(irq));

   pot_ext_clock pot_ext_clock_inst (.clock_in(clock_in), .pin_out(ext_pin));

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] resp);
      logic a, w, aw_hs, w_hs, b_hs;
      int g;
      a = 1'h1;
      w = 1'h1;
      b_hs = 1'h0;
      resp = 2'h0;
      g = 0;
      @(posedge clock_in);
      awaddr <= ADDR_W'({idx, 2'h0});
      wdata <= {24'h0, val};
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!b_hs && g < 200) begin
         // settled mid-cycle values are what the next rising edge samples
         @(negedge clock_in);
         aw_hs = a && awready === 1'h1;
         w_hs = w && wready === 1'h1;
         b_hs = !a && !w && bvalid === 1'h1;
         resp = bresp;
         @(posedge clock_in);
         g++;
         if (aw_hs) begin
            a = 1'h0;
            awvalid <= 1'h0;
         end
         if (w_hs) begin
            w = 1'h0;
            wvalid <= 1'h0;
         end
      end
      if (!b_hs) begin
         mismatches++;
         conclude();
      end
      bready <= 1'h0;
      t_evt = int'($time / 10);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
      logic a, ar_hs, r_hs;
      int g;
      a = 1'h1;
      r_hs = 1'h0;
      data = 32'h0;
      resp = 2'h0;
      g = 0;
      @(posedge clock_in);
      araddr <= ADDR_W'({idx, 2'h0});
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!r_hs && g < 200) begin
         @(negedge clock_in);
         ar_hs = a && arready === 1'h1;
         r_hs = !a && rvalid === 1'h1;
         data = rdata;
         resp = rresp;
         @(posedge clock_in);
         g++;
         if (ar_hs) begin
            a = 1'h0;
            arvalid <= 1'h0;
         end
      end
      if (!r_hs) begin
         mismatches++;
         conclude();
      end
      rready <= 1'h0;
      t_evt = int'($time / 10);
   endtask

   task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      check(name, d, exp);
   endtask

   // control write, settle, then clear count low byte and prescaler
   task automatic setup(input logic [7:0] ctl);
      logic [1:0] r;
      wr(IDX_CONTROL, ctl, r);
      repeat (10) @(posedge clock_in);
      wr(IDX_COUNT_LO, 8'h00, r);
   endtask

   function automatic int period(input int code);
      return OSC_PER_INSTR << ((code > 8) ? 8 : code);
   endfunction

   function automatic logic in_rng(input logic [31:0] v, input int lo, input int hi);
      return (v >= 32'(lo)) && (v <= 32'(hi));
   endfunction

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] v, h;
      int t0, p, e, i;
      int codes [10];
      void'($urandom(32'he4e2));
      codes = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15};
      repeat (6) @(posedge clock_in);
      arst_n <= 1'h1;
      rchk("ctl_reset", IDX_CONTROL, {24'h0, CTL_RESET});
      rchk("lo_reset", IDX_COUNT_LO, 32'h0);
      rchk("hi_reset", IDX_COUNT_HI, 32'h0);
      rchk("mask_reset", IDX_IRQ_MASK, {31'h0, IRQ_MASK_RESET});
      rd(8'h3f, d, r);
      check("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      check("unmapped_rdata", d, 32'h0);
      wr(8'h3f, 8'hff, r);
      check("unmapped_bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom);
         wr(IDX_CONTROL, v, r);
         rchk("ctl_readback", IDX_CONTROL, {24'h0, v & CTL_WMASK});
      end
      wr(IDX_CONTROL, 8'h40, r);
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom);
         h = 8'($urandom);
         wr(IDX_COUNT_LO, v, r);
         wr(IDX_COUNT_HI, h, r);
         rchk("lo_readback", IDX_COUNT_LO, {24'h0, v});
         rchk("hi_readback", IDX_COUNT_HI, {24'h0, h});
      end
      for (i = 0; i < 10; i++) begin
         setup({1'h0, 1'($urandom), 1'h1, 4'(codes[i]), 1'h0});
         t0 = t_evt;
         p = period(codes[i]);
         repeat (5 * p) @(posedge clock_in);
         rd(IDX_COUNT_LO, d, r);
         e = (t_evt - t0) / p;
         check("ratio_count", {31'h0, in_rng(d, e - 1, e + 1)}, 32'h1);
      end
      setup(8'h30);
      wr(IDX_COUNT_LO, 8'h10, r);
      repeat (900) @(posedge clock_in);
      wr(IDX_COUNT_HI, 8'h00, r);
      repeat (900) @(posedge clock_in);
      rchk("ps_cleared", IDX_COUNT_LO, 32'h10);
      repeat (300) @(posedge clock_in);
      rchk("ps_after", IDX_COUNT_LO, 32'h11);
      setup(8'h40);
      pot_ext_clock_inst.toggle(21, 6);
      repeat (10) @(posedge clock_in);
      rchk("rising_edges", IDX_COUNT_LO, 32'd11);
      setup(8'h00);
      pot_ext_clock_inst.toggle(21, 6);
      repeat (10) @(posedge clock_in);
      rchk("falling_edges", IDX_COUNT_LO, 32'd11);
      setup(8'h44);
      pot_ext_clock_inst.toggle(64, 1);
      repeat (10) @(posedge clock_in);
      rd(IDX_COUNT_LO, d, r);
      check("fast_prescaled", {31'h0, in_rng(d, 7, 9)}, 32'h1);
      wr(IDX_IRQ_MASK, 8'h01, r);
      setup(8'h20);
      wr(IDX_COUNT_LO, 8'hf0, r);
      wr(IDX_COUNT_HI, 8'hff, r);
      repeat (80) @(posedge clock_in);
      check("irq_on_wrap", {31'h0, irq}, 32'h1);
      rchk("flag_on_wrap", IDX_IRQ_STATUS, 32'h1);
      rchk("hi_wrapped", IDX_COUNT_HI, 32'h0);
      @(posedge clock_in);
      vec_ack <= 1'h1;
      @(posedge clock_in);
      vec_ack <= 1'h0;
      repeat (2) @(posedge clock_in);
      check("irq_vector", {31'h0, irq}, 32'h0);
      rchk("flag_vector", IDX_IRQ_STATUS, 32'h0);
      wr(IDX_IRQ_MASK, 8'h00, r);
      wr(IDX_COUNT_LO, 8'hf0, r);
      wr(IDX_COUNT_HI, 8'hff, r);
      repeat (80) @(posedge clock_in);
      check("irq_masked", {31'h0, irq}, 32'h0);
      rchk("flag_masked", IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_MASK, 8'h01, r);
      repeat (2) @(posedge clock_in);
      check("irq_unmasked", {31'h0, irq}, 32'h1);
      wr(IDX_IRQ_STATUS, 8'h01, r);
      repeat (2) @(posedge clock_in);
      rchk("flag_w1c", IDX_IRQ_STATUS, 32'h0);
      check("irq_w1c", {31'h0, irq}, 32'h0);
      conclude();
   end

   initial begin
      #900000;
      mismatches++;
      conclude();
   end
endmodule
